// [hw/bram_pkg.sv]
package bram_pkg;
	localparam int ADDR_W = 16;
	localparam int LANE_W = 20;
	localparam int HALF_W = 40;
	localparam int ROW_LSB = 7;
	localparam int ROW_W = 9;
	localparam int ROWS = 512;
	localparam int HALF_COL_TOP = 5;
	localparam int FULL_COL_TOP = 6;
	localparam int NARROW_LIMIT = 5;
	localparam int SKIP_PERIOD = 5;
	localparam logic [39:0] SKIP_MASK = 40'h8421084210;
	localparam logic [19:0] DOUT_RST = 20'h00000;

	typedef enum logic [2:0] {
		W1 = 3'h0,
		W2 = 3'h1,
		W5 = 3'h2,
		W10 = 3'h3,
		W20 = 3'h4,
		W40 = 3'h5
	} width_t;

	function automatic int width_bits(input width_t c);
		unique case (c)
			W1: return 1;
			W2: return 2;
			W5: return 5;
			W10: return 10;
			W20: return 20;
			default: return 40;
		endcase
	endfunction
endpackage

// [hw/bram_half.sv]
`timescale 1ns/100ps
module bram_half #(
	parameter int ROWS_P = bram_pkg::ROWS,
	parameter int WIDTH_P = bram_pkg::HALF_W
) (
	input wire logic core_clk_i,
	input wire logic [1:0] rd_i,
	input wire logic [1:0][$clog2(ROWS_P)-1:0] row_i,
	input wire logic [1:0][WIDTH_P-1:0] wbit_i,
	input wire logic [1:0][WIDTH_P-1:0] wdata_i,
	output logic [1:0][WIDTH_P-1:0] rdata_o
);
	import bram_pkg::*;

	if (ROWS_P < 2 || WIDTH_P < 1) begin : g_bad
		$error("bram_half: unusable geometry");
	end

	logic [WIDTH_P-1:0] mem [ROWS_P];

	// same row and bit written from both ports in one cycle: port 1's write lands last and wins
	always_ff @(posedge core_clk_i) begin
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < WIDTH_P; i++) begin
				if (wbit_i[p][i]) begin
					mem[row_i[p]][i] <= wdata_i[p][i];
				end
			end
			if (rd_i[p]) begin
				rdata_o[p] <= mem[row_i[p]];
			end
		end
	end
endmodule

// [hw/bram_cell.sv]
`timescale 1ns/100ps
// What this block does
// - two ports read or write in parallel
// - each port has own clock and width
// - half cell ports reach only their own half; full cell ports reach the whole array
// - half cell 20 bits, full cell 40
// - half cell widths and column address bits
// - full cell widths, 40 bits joins sub-ports
// - full cell uses sub-port 0 controls only
// - second half wired like the first
// - simple mode: one wide read output
// - simple mode: A writes, B reads
// - write needs enable and write enable
// - half simple: 40 bits, b over a
// - full simple: 80 bits b1 b0 a1 a0
// - 80 bits only in full simple mode
// - controls forwarded to neighbouring cell
// - cascade also forwards data, one bit only
// - cascade runs downward, forming 64K by 1
// - cascade pins are the upper cell's
// - address bit 0 picks upper or lower
// - narrow words leave every fifth bit unused
// - output register adds one port clock
// - clock, enable, write enable individually invertible
module bram_cell (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic full_cell_i,
	input wire logic simple_two_port_mode_i,
	input wire bram_pkg::width_t port_a_width_i,
	input wire bram_pkg::width_t port_b_width_i,
	input wire logic [1:0] out_reg_i,
	input wire logic [3:0] clock_invert_i,
	input wire logic [3:0] enable_invert_i,
	input wire logic [3:0] write_enable_invert_i,
	input wire logic forward_select_i,
	input wire logic cascade_mode_i,
	input wire logic cascade_lower_i,
	input wire logic port_a_sub0_clock_i,
	input wire logic port_a_sub0_enable_i,
	input wire logic port_a_sub0_write_enable_i,
	input wire logic [15:0] port_a_sub0_address_i,
	input wire logic [19:0] port_a_sub0_data_in_i,
	input wire logic [19:0] port_a_sub0_bit_mask_i,
	output logic [19:0] port_a_sub0_data_out_o,
	input wire logic port_b_sub0_clock_i,
	input wire logic port_b_sub0_enable_i,
	input wire logic port_b_sub0_write_enable_i,
	input wire logic [15:0] port_b_sub0_address_i,
	input wire logic [19:0] port_b_sub0_data_in_i,
	input wire logic [19:0] port_b_sub0_bit_mask_i,
	output logic [19:0] port_b_sub0_data_out_o,
	input wire logic port_a_sub1_clock_i,
	input wire logic port_a_sub1_enable_i,
	input wire logic port_a_sub1_write_enable_i,
	input wire logic [15:0] port_a_sub1_address_i,
	input wire logic [19:0] port_a_sub1_data_in_i,
	input wire logic [19:0] port_a_sub1_bit_mask_i,
	output logic [19:0] port_a_sub1_data_out_o,
	input wire logic port_b_sub1_clock_i,
	input wire logic port_b_sub1_enable_i,
	input wire logic port_b_sub1_write_enable_i,
	input wire logic [15:0] port_b_sub1_address_i,
	input wire logic [19:0] port_b_sub1_data_in_i,
	input wire logic [19:0] port_b_sub1_bit_mask_i,
	output logic [19:0] port_b_sub1_data_out_o,
	input wire logic [3:0] fwd_clock_i,
	input wire logic [3:0] fwd_enable_i,
	input wire logic [3:0] fwd_write_enable_i,
	input wire logic [3:0][15:0] fwd_address_i,
	input wire logic [1:0] fwd_data_i,
	input wire logic [1:0] fwd_mask_i,
	output logic [3:0] fwd_clock_o,
	output logic [3:0] fwd_enable_o,
	output logic [3:0] fwd_write_enable_o,
	output logic [3:0][15:0] fwd_address_o,
	output logic [1:0] fwd_data_o,
	output logic [1:0] fwd_mask_o,
	input wire logic [1:0] casc_rdata_i,
	output logic [1:0] casc_rdata_o
);
	import bram_pkg::*;

	typedef struct packed {
		logic [3:0] clk_q;
		logic [3:0] pend;
		logic [3:0][6:0] lbase;
		logic [1:0] casc_low;
		logic [3:0][19:0] stage;
		logic [3:0][19:0] dout;
		logic [3:0] fclk;
		logic [3:0] fen;
		logic [3:0] fwe;
		logic [3:0][15:0] faddr;
		logic [1:0] fdat;
		logic [1:0] fmsk;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic [3:0] lclk, len, lwe, clk_e, en_e, we_e, edge_l, rdl;
	logic [3:0][15:0] laddr, eaddr;
	logic [3:0][19:0] ldi, lbm, edi, ebm, rdv;
	logic [1:0][1:0] mrd;
	logic [1:0][1:0][8:0] mrow;
	logic [1:0][1:0][39:0] mwbit, mwdata, mrdata;
	logic casc_on;
	width_t wc [2];

	// lane order: 0 = a0, 1 = b0, 2 = a1, 3 = b1
	assign lclk = {port_b_sub1_clock_i, port_a_sub1_clock_i, port_b_sub0_clock_i,
		port_a_sub0_clock_i};
	assign len = {port_b_sub1_enable_i, port_a_sub1_enable_i, port_b_sub0_enable_i,
		port_a_sub0_enable_i};
	assign lwe = {port_b_sub1_write_enable_i, port_a_sub1_write_enable_i,
		port_b_sub0_write_enable_i, port_a_sub0_write_enable_i};
	assign laddr = {port_b_sub1_address_i, port_a_sub1_address_i, port_b_sub0_address_i,
		port_a_sub0_address_i};
	assign ldi = {port_b_sub1_data_in_i, port_a_sub1_data_in_i, port_b_sub0_data_in_i,
		port_a_sub0_data_in_i};
	assign lbm = {port_b_sub1_bit_mask_i, port_a_sub1_bit_mask_i, port_b_sub0_bit_mask_i,
		port_a_sub0_bit_mask_i};

	// logical bit -> physical bit; narrow words skip every fifth physical bit
	function automatic logic [159:0] spread(input logic [39:0] d, input logic [39:0] m,
		input int lb, input int off, input int w);
		int ph;
		spread = '0;
		for (int i = 0; i < HALF_W; i++) begin
			ph = lb + i;
			if (w < NARROW_LIMIT) begin
				ph = ph + ph / (SKIP_PERIOD - 1);
			end
			ph = ph + off;
			if (i < w && ph < 2 * HALF_W) begin
				spread[ph] = d[i];
				spread[2 * HALF_W + ph] = m[i];
			end
		end
	endfunction

	function automatic logic [39:0] pick(input logic [79:0] row, input int lb, input int off,
		input int w);
		int ph;
		pick = '0;
		for (int i = 0; i < HALF_W; i++) begin
			ph = lb + i;
			if (w < NARROW_LIMIT) begin
				ph = ph + ph / (SKIP_PERIOD - 1);
			end
			ph = ph + off;
			if (i < w && ph < 2 * HALF_W) begin
				pick[i] = row[ph];
			end
		end
	endfunction

	always_comb begin
		int h, p, c, off, k, w, colw, col, lb, q, oc;
		logic act;
		logic [159:0] sp;
		logic [39:0] dw, mw, wd;
		h = 0;
		p = 0;
		c = 0;
		off = 0;
		k = 0;
		w = 0;
		colw = 0;
		col = 0;
		lb = 0;
		q = 0;
		oc = 0;
		act = 1'b0;
		sp = '0;
		dw = '0;
		mw = '0;
		wd = '0;
		nxt_st = st_ff;
		nxt_st.pend = '0;
		mrd = '0;
		mrow = '0;
		mwbit = '0;
		mwdata = '0;
		rdv = '0;
		rdl = '0;
		// forwarded controls arrive raw; each cell applies its own inversion
		clk_e = (forward_select_i ? fwd_clock_i : lclk) ^ clock_invert_i;
		en_e = (forward_select_i ? fwd_enable_i : len) ^ enable_invert_i;
		we_e = (forward_select_i ? fwd_write_enable_i : lwe) ^ write_enable_invert_i;
		eaddr = forward_select_i ? fwd_address_i : laddr;
		edi = ldi;
		ebm = lbm;
		casc_on = cascade_mode_i && full_cell_i && !simple_two_port_mode_i;
		if (casc_on && forward_select_i) begin
			edi[0][0] = fwd_data_i[0];
			edi[1][0] = fwd_data_i[1];
			ebm[0][0] = fwd_mask_i[0];
			ebm[1][0] = fwd_mask_i[1];
		end
		// port clocks are sampled levels; an access happens on their rising edge
		edge_l = clk_e & ~st_ff.clk_q;
		nxt_st.clk_q = clk_e;
		for (int i = 0; i < 2; i++) begin
			wc[i] = (i == 1) ? port_b_width_i : port_a_width_i;
			if (casc_on) begin
				wc[i] = W1;
			end else if (!full_cell_i && wc[i] > W20) begin
				wc[i] = W20;
			end
		end
		// agent g = 2*half + port letter; the second half mirrors the first
		for (int g = 0; g < 4; g++) begin
			h = g / 2;
			p = g % 2;
			c = full_cell_i ? p : g;
			off = full_cell_i ? 0 : HALF_W * h;
			act = edge_l[c] && en_e[c] && (!casc_on || eaddr[c][0] == cascade_lower_i);
			mrow[h][p] = eaddr[c][ROW_LSB +: ROW_W];
			if (simple_two_port_mode_i) begin
				if (full_cell_i) begin
					dw = (h == 1) ? {edi[3], edi[1]} : {edi[2], edi[0]};
					mw = (h == 1) ? {ebm[3], ebm[1]} : {ebm[2], ebm[0]};
				end else begin
					dw = {edi[2 * h + 1], edi[2 * h]};
					mw = {ebm[2 * h + 1], ebm[2 * h]};
				end
				if (p == 0) begin
					mwbit[h][0] = (act && we_e[c]) ? mw : '0;
					mwdata[h][0] = dw;
				end else begin
					mrd[h][1] = act;
					nxt_st.pend[g] = act;
					nxt_st.lbase[g] = '0;
				end
			end else begin
				k = int'(wc[p]) + 1;
				w = width_bits(wc[p]);
				colw = (full_cell_i ? FULL_COL_TOP : HALF_COL_TOP) - k + 1;
				col = int'(eaddr[c] >> k) & ((1 << colw) - 1);
				lb = col * w;
				dw = (full_cell_i && wc[p] == W40) ? {edi[p + 2], edi[p]} : {20'h00000, edi[c]};
				mw = (full_cell_i && wc[p] == W40) ? {ebm[p + 2], ebm[p]} : {20'h00000, ebm[c]};
				sp = spread(dw, mw, lb, off, w);
				mwbit[h][p] = (act && we_e[c]) ? sp[2 * HALF_W + HALF_W * h +: HALF_W] : '0;
				mwdata[h][p] = sp[HALF_W * h +: HALF_W];
				mrd[h][p] = act && !we_e[c];
				nxt_st.pend[g] = act && !we_e[c];
				nxt_st.lbase[g] = 7'(lb);
			end
			// any read picks which cell owns the upper pins, a lower-cell read included
			if (g < 2 && edge_l[c] && en_e[c] && !we_e[c]) begin
				nxt_st.casc_low[g] = eaddr[c][0];
			end
		end
		for (int g = 0; g < 4; g++) begin
			h = g / 2;
			p = g % 2;
			if (st_ff.pend[g]) begin
				if (simple_two_port_mode_i) begin
					if (full_cell_i) begin
						rdv[0] = mrdata[0][1][19:0];
						rdv[2] = mrdata[0][1][39:20];
						rdv[1] = mrdata[1][1][19:0];
						rdv[3] = mrdata[1][1][39:20];
						rdl = '1;
					end else begin
						rdv[2 * h] = mrdata[h][1][19:0];
						rdv[2 * h + 1] = mrdata[h][1][39:20];
						rdl[2 * h] = 1'b1;
						rdl[2 * h + 1] = 1'b1;
					end
				end else if (!full_cell_i || h == 0) begin
					off = full_cell_i ? 0 : HALF_W * h;
					wd = pick({mrdata[1][p], mrdata[0][p]}, int'(st_ff.lbase[g]), off,
						width_bits(wc[p]));
					rdv[g] = wd[19:0];
					rdl[g] = 1'b1;
					if (full_cell_i && wc[p] == W40) begin
						rdv[p + 2] = wd[39:20];
						rdl[p + 2] = 1'b1;
					end
				end
			end
		end
		for (int l = 0; l < 4; l++) begin
			q = l % 2;
			oc = simple_two_port_mode_i ? (full_cell_i ? 1 : (l | 1)) : (full_cell_i ? q : l);
			if (out_reg_i[simple_two_port_mode_i ? 1 : q]) begin
				if (rdl[l]) begin
					nxt_st.stage[l] = rdv[l];
				end
				if (edge_l[oc]) begin
					nxt_st.dout[l] = st_ff.stage[l];
				end
			end else if (rdl[l]) begin
				nxt_st.dout[l] = rdv[l];
			end
		end
		// the upper cell of a pair owns the pins; lower-cell reads come back over casc_rdata_i
		if (casc_on && !cascade_lower_i) begin
			for (int i = 0; i < 2; i++) begin
				if (st_ff.casc_low[i]) begin
					nxt_st.dout[i][0] = casc_rdata_i[i];
				end
			end
		end
		nxt_st.fclk = forward_select_i ? fwd_clock_i : lclk;
		nxt_st.fen = forward_select_i ? fwd_enable_i : len;
		nxt_st.fwe = forward_select_i ? fwd_write_enable_i : lwe;
		nxt_st.faddr = eaddr;
		nxt_st.fdat = {edi[1][0], edi[0][0]};
		nxt_st.fmsk = {ebm[1][0], ebm[0][0]};
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	for (genvar h = 0; h < 2; h++) begin : g_half
		bram_half #(.ROWS_P(ROWS), .WIDTH_P(HALF_W)) u_half (
			.core_clk_i(core_clk_i),
			.rd_i(mrd[h]),
			.row_i(mrow[h]),
			.wbit_i(mwbit[h]),
			.wdata_i(mwdata[h]),
			.rdata_o(mrdata[h])
		);
	end

	assign port_a_sub0_data_out_o = st_ff.dout[0];
	assign port_b_sub0_data_out_o = st_ff.dout[1];
	assign port_a_sub1_data_out_o = st_ff.dout[2];
	assign port_b_sub1_data_out_o = st_ff.dout[3];
	assign fwd_clock_o = st_ff.fclk;
	assign fwd_enable_o = st_ff.fen;
	assign fwd_write_enable_o = st_ff.fwe;
	assign fwd_address_o = st_ff.faddr;
	assign fwd_data_o = st_ff.fdat;
	assign fwd_mask_o = st_ff.fmsk;
	assign casc_rdata_o = {st_ff.dout[1][0], st_ff.dout[0][0]};

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence a_issue_s;
		edge_l[0] && en_e[0] && !we_e[0] && !simple_two_port_mode_i && !casc_on;
	endsequence

	read_sync_a: assert property (
		(a_issue_s ##0 !out_reg_i[0]) |-> ##1 st_ff.pend[0] ##1
			(port_a_sub0_data_out_o == $past(rdv[0])))
		else $error("port a read data not presented after its edge");
	out_hold_a: assert property (
		(out_reg_i[0] && !simple_two_port_mode_i && !casc_on && !edge_l[0])
			|=> $stable(port_a_sub0_data_out_o))
		else $error("registered output changed without a port clock edge");
	half_width_a: assert property (
		!full_cell_i |-> (wc[0] != W40 && wc[1] != W40))
		else $error("half cell accepted a 40 bit port");
	full_ctrl_a: assert property (
		(full_cell_i && !simple_two_port_mode_i) |-> (mrow[0][0] == mrow[1][0]
			&& mrd[0][0] == mrd[1][0] && mrow[0][1] == mrow[1][1]))
		else $error("full cell halves not steered by one control set");
	sdp_noread_a: assert property (
		simple_two_port_mode_i |-> (mrd[0][0] == 1'b0 && mrd[1][0] == 1'b0))
		else $error("simple mode port a performed a read");
	sdp_nowrite_a: assert property (
		simple_two_port_mode_i |-> (mwbit[0][1] == '0 && mwbit[1][1] == '0))
		else $error("simple mode port b performed a write");
	write_qual_a: assert property (
		(mwbit[0][0] != '0) |-> (edge_l[0] && en_e[0] && we_e[0]))
		else $error("write without enable and write enable");
	read_qual_a: assert property (
		(simple_two_port_mode_i && mrd[0][1]) |-> (edge_l[1] && en_e[1]))
		else $error("simple mode read without read enable");
	casc_pick_a: assert property (
		(casc_on && mrd[0][1]) |-> (eaddr[1][0] == cascade_lower_i))
		else $error("cascade access in the cell not chosen by address bit 0");
	skip_bit_a: assert property (
		(!simple_two_port_mode_i && wc[0] < W5) |-> ((mwbit[0][0] & SKIP_MASK) == '0))
		else $error("narrow word touched a skipped physical bit");
endmodule

// [bench/fabric_lane.sv]
`timescale 1ns/100ps
// one lane of fabric user logic; released lines show the inverse of the last value
module fabric_lane (
	input wire logic core_clk_i,
	output logic clock_o,
	output logic enable_o,
	output logic write_enable_o,
	output logic [15:0] address_o,
	output logic [19:0] data_in_o,
	output logic [19:0] bit_mask_o
);
	initial begin
		clock_o = 1'b0;
		enable_o = 1'b0;
		write_enable_o = 1'b0;
		address_o = 16'h0000;
		data_in_o = 20'h00000;
		bit_mask_o = 20'h00000;
	end
	// high for one core cycle and low for at least one, so the core always sees the rise
	task automatic access(input logic we, input logic [15:0] a, input logic [19:0] d,
		input logic [19:0] m);
		@(posedge core_clk_i);
		clock_o <= 1'b1;
		enable_o <= 1'b1;
		write_enable_o <= we;
		address_o <= a;
		data_in_o <= d;
		bit_mask_o <= m;
		@(posedge core_clk_i);
		clock_o <= 1'b0;
		enable_o <= 1'b0;
		write_enable_o <= ~we;
		address_o <= ~a;
		data_in_o <= ~d;
		bit_mask_o <= ~m;
	endtask
endmodule

// [bench/dual_port_block_ram_modes_tb_top.sv]
`timescale 1ns/100ps
module dual_port_block_ram_modes_tb_top;
	import bram_pkg::*;
	typedef struct packed {
		logic full;
		logic simple_two_port_mode;
		width_t w;
		logic [3:0] wl;
		logic [3:0] rl;
		logic x;
		logic [15:0] addr;
		logic [19:0] base;
		logic [19:0] cmp;
	} row_t;
	// lanes: 0 a0, 1 b0, 2 a1, 3 b1; x set means the read lane shows the other port's data
	localparam row_t CASES [10] = '{
		'{1'b0, 1'b0, W20, 4'h1, 4'h2, 1'b1, 16'h0080, 20'h12345, 20'hFFFFF},
		'{1'b0, 1'b0, W20, 4'h4, 4'h8, 1'b1, 16'h0FA0, 20'hABCDE, 20'hFFFFF},
		'{1'b0, 1'b0, W1, 4'h1, 4'h2, 1'b1, 16'h003E, 20'h00001, 20'h00001},
		'{1'b0, 1'b0, W10, 4'h2, 4'h1, 1'b1, 16'h0030, 20'h002AB, 20'h003FF},
		'{1'b1, 1'b0, W40, 4'h5, 4'hA, 1'b1, 16'hFFC0, 20'h5A5A5, 20'hFFFFF},
		'{1'b1, 1'b0, W5, 4'h1, 4'h2, 1'b1, 16'h0008, 20'h00013, 20'h0001F},
		'{1'b1, 1'b0, W2, 4'h1, 4'h2, 1'b1, 16'h7FFC, 20'h00002, 20'h00003},
		'{1'b0, 1'b0, W40, 4'h4, 4'h8, 1'b1, 16'h0020, 20'h0BEEF, 20'hFFFFF},
		'{1'b0, 1'b1, W20, 4'h3, 4'h3, 1'b0, 16'h3F80, 20'h0F00F, 20'hFFFFF},
		'{1'b1, 1'b1, W20, 4'hF, 4'hF, 1'b0, 16'h1234, 20'hC3C3C, 20'hFFFFF}
	};
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic full = 1'b0;
	logic simple_two_port_mode = 1'b0;
	logic casc = 1'b0;
	width_t wa = W20;
	width_t wb = W20;
	logic [1:0] oreg = 2'h0;
	logic [3:0] cinv = 4'h0;
	logic [3:0] einv = 4'h0;
	logic [3:0] winv = 4'h0;
	logic [3:0] clk_l, en_l, we_l;
	logic [3:0][15:0] addr_l;
	logic [3:0][19:0] di_l, bm_l;
	logic [1:0][3:0][19:0] dout;
	logic [1:0][3:0] fc, fe, fw;
	logic [1:0][3:0][15:0] fa;
	logic [1:0][1:0] fd, fm, cr;
	int err_total = 0;
	int checks = 0;

	always #20 core_clk = ~core_clk;

	for (genvar j = 0; j < 4; j++) begin : g_lane
		fabric_lane i_lane (.core_clk_i(core_clk), .clock_o(clk_l[j]), .enable_o(en_l[j]),
			.write_enable_o(we_l[j]), .address_o(addr_l[j]), .data_in_o(di_l[j]),
			.bit_mask_o(bm_l[j]));
	end
	// cell 1 is the lower neighbour: it takes its controls forwarded from cell 0
	for (genvar c = 0; c < 2; c++) begin : g_cell
		bram_cell i_dut (.core_clk_i(core_clk), .reset_i(reset), .full_cell_i(full),
			.simple_two_port_mode_i(simple_two_port_mode), .port_a_width_i(wa), .port_b_width_i(wb),
			.out_reg_i(oreg), .clock_invert_i(cinv), .enable_invert_i(einv),
			.write_enable_invert_i(winv), .forward_select_i(c == 1), .cascade_mode_i(casc),
			.cascade_lower_i(c == 1),
			.port_a_sub0_clock_i(clk_l[0]), .port_a_sub0_enable_i(en_l[0]),
			.port_a_sub0_write_enable_i(we_l[0]), .port_a_sub0_address_i(addr_l[0]),
			.port_a_sub0_data_in_i(di_l[0]), .port_a_sub0_bit_mask_i(bm_l[0]),
			.port_a_sub0_data_out_o(dout[c][0]),
			.port_b_sub0_clock_i(clk_l[1]), .port_b_sub0_enable_i(en_l[1]),
			.port_b_sub0_write_enable_i(we_l[1]), .port_b_sub0_address_i(addr_l[1]),
			.port_b_sub0_data_in_i(di_l[1]), .port_b_sub0_bit_mask_i(bm_l[1]),
			.port_b_sub0_data_out_o(dout[c][1]),
			.port_a_sub1_clock_i(clk_l[2]), .port_a_sub1_enable_i(en_l[2]),
			.port_a_sub1_write_enable_i(we_l[2]), .port_a_sub1_address_i(addr_l[2]),
			.port_a_sub1_data_in_i(di_l[2]), .port_a_sub1_bit_mask_i(bm_l[2]),
			.port_a_sub1_data_out_o(dout[c][2]),
			.port_b_sub1_clock_i(clk_l[3]), .port_b_sub1_enable_i(en_l[3]),
			.port_b_sub1_write_enable_i(we_l[3]), .port_b_sub1_address_i(addr_l[3]),
			.port_b_sub1_data_in_i(di_l[3]), .port_b_sub1_bit_mask_i(bm_l[3]),
			.port_b_sub1_data_out_o(dout[c][3]),
			.fwd_clock_i(fc[1-c]), .fwd_enable_i(fe[1-c]), .fwd_write_enable_i(fw[1-c]),
			.fwd_address_i(fa[1-c]), .fwd_data_i(fd[1-c]), .fwd_mask_i(fm[1-c]),
			.fwd_clock_o(fc[c]), .fwd_enable_o(fe[c]), .fwd_write_enable_o(fw[c]),
			.fwd_address_o(fa[c]), .fwd_data_o(fd[c]), .fwd_mask_o(fm[c]),
			.casc_rdata_i(cr[1-c]), .casc_rdata_o(cr[c]));
	end

	function automatic logic [19:0] wd(input logic [19:0] b, input int j);
		return b + 20'(j) * 20'h11111;
	endfunction

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic cfg(input logic f, input logic s, input width_t w);
		@(posedge core_clk);
		full <= f;
		simple_two_port_mode <= s;
		wa <= w;
		wb <= w;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic go(input logic [3:0] l, input logic we, input logic [15:0] a,
		input logic [19:0] b, input logic [19:0] m);
		fork
			if (l[0]) g_lane[0].i_lane.access(we, a, wd(b, 0), m);
			if (l[1]) g_lane[1].i_lane.access(we, a, wd(b, 1), m);
			if (l[2]) g_lane[2].i_lane.access(we, a, wd(b, 2), m);
			if (l[3]) g_lane[3].i_lane.access(we, a, wd(b, 3), m);
		join
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge core_clk);
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		settle(1);
		for (int j = 0; j < 4; j++) check(dout[0][j], DOUT_RST);
		$display("test reset done");
		foreach (CASES[i]) begin
			cfg(CASES[i].full, CASES[i].simple_two_port_mode, CASES[i].w);
			// in simple mode the b lanes carry write data but must not read the same word
			einv <= CASES[i].simple_two_port_mode ? 4'hA : 4'h0;
			go(CASES[i].wl, 1'b1, CASES[i].addr, CASES[i].base, 20'hFFFFF);
			einv <= 4'h0;
			go(CASES[i].rl, 1'b0, CASES[i].addr, CASES[i].base, 20'h00000);
			settle(4);
			for (int j = 0; j < 4; j++) begin
				if (CASES[i].rl[j]) begin
					check(dout[0][j] & CASES[i].cmp,
						wd(CASES[i].base, j ^ CASES[i].x) & CASES[i].cmp);
				end
			end
			$display("test row %0d done", i);
		end
		cfg(1'b0, 1'b0, W20);
		go(4'h1, 1'b1, 16'h0100, 20'hFFFFF, 20'hFFFFF);
		go(4'h1, 1'b1, 16'h0100, 20'h00000, 20'h000FF);
		go(4'h2, 1'b0, 16'h0100, 20'h00000, 20'h00000);
		settle(4);
		check(dout[0][1], 20'hFFF00);
		// distinct addresses on the two ports in the same cycle
		fork
			g_lane[0].i_lane.access(1'b1, 16'h0180, 20'h24680, 20'hFFFFF);
			g_lane[1].i_lane.access(1'b0, 16'h0100, 20'h00000, 20'h00000);
		join
		settle(4);
		check(dout[0][1], 20'hFFF00);
		go(4'h2, 1'b0, 16'h0180, 20'h00000, 20'h00000);
		settle(4);
		check(dout[0][1], 20'h24680);
		$display("test mask and parallel done");
		@(posedge core_clk);
		winv <= 4'h1;
		go(4'h1, 1'b0, 16'h0200, 20'h13579, 20'hFFFFF);
		@(posedge core_clk);
		winv <= 4'h0;
		einv <= 4'h1;
		go(4'h1, 1'b1, 16'h0200, 20'h0AAAA, 20'hFFFFF);
		@(posedge core_clk);
		einv <= 4'h0;
		go(4'h2, 1'b0, 16'h0200, 20'h00000, 20'h00000);
		settle(4);
		check(dout[0][1], 20'h13579);
		@(posedge core_clk);
		cinv <= 4'h2;
		@(posedge core_clk);
		einv <= 4'h2;
		// inverted clock and enable: the released half of the access reads 16'h0180
		g_lane[1].i_lane.access(1'b1, 16'hFE7F, 20'h00000, 20'h00000);
		settle(4);
		check(dout[0][1], 20'h24680);
		@(posedge core_clk);
		cinv <= 4'h0;
		einv <= 4'h0;
		$display("test inversion done");
		@(posedge core_clk);
		oreg <= 2'h3;
		// two reads fill the output register with a known word first
		go(4'h2, 1'b0, 16'h0200, 20'h00000, 20'h00000);
		go(4'h2, 1'b0, 16'h0200, 20'h00000, 20'h00000);
		go(4'h1, 1'b1, 16'h0200, 20'h2468A, 20'hFFFFF);
		go(4'h2, 1'b0, 16'h0200, 20'h00000, 20'h00000);
		settle(4);
		check(dout[0][1], 20'h13579);
		go(4'h2, 1'b0, 16'h0200, 20'h00000, 20'h00000);
		settle(4);
		check(dout[0][1], 20'h2468A);
		$display("test output register done");
		@(posedge core_clk);
		oreg <= 2'h0;
		casc <= 1'b1;
		cfg(1'b1, 1'b0, W1);
		go(4'h1, 1'b1, 16'h0001, 20'h00001, 20'hFFFFF);
		go(4'h1, 1'b1, 16'h0000, 20'h00000, 20'hFFFFF);
		go(4'h2, 1'b0, 16'h0001, 20'h00000, 20'h00000);
		settle(8);
		check(dout[0][1] & 20'h00001, 20'h00001);
		go(4'h2, 1'b0, 16'h0000, 20'h00000, 20'h00000);
		settle(8);
		check(dout[0][1] & 20'h00001, 20'h00000);
		$display("test cascade done");
		wrap_up();
	end
endmodule
